// File: design/subtract_swap_skip_instr_exec.sv
// Execution unit for subtract, nibble swap and zero-skip instructions
//
// Function
// - Subtract-into-memory writes accumulator minus memory byte back to memory, accumulator unchanged.
// - Every subtract clears the borrow-out flag on a negative difference and sets it otherwise.
// - Subtracts update exactly the six arithmetic flags and nothing else.
// - Subtract-immediate stores accumulator minus the literal in the accumulator.
// - In-place swap exchanges the two nibbles of the memory byte, writes it back, keeps flags.
// - Swap into accumulator loads the nibble-swapped memory byte into the accumulator, memory and flags kept.
// - Skip-if-nil writes the byte back unchanged and skips when it is zero, flags kept.
// - A taken skip inserts one dummy instruction cycle, so the skip takes two cycles.
// - Load-and-skip copies the byte to the accumulator and skips when it is zero, flags kept.
// - Bit-test skip skips only when the selected bit is zero, flags kept.
// - Register subtract stores accumulator minus memory byte in the accumulator with the six flags.
`timescale 1ns/10ps
module subtract_swap_skip_instr_exec
   import sub_swap_skip_pkg::*;
#(
   parameter int DATA_W = DATA_WIDTH
)(
   input  wire logic                      i_ref_clk,
   input  wire logic                      i_resetn,
   input  wire logic                      i_op_valid,
   input  wire logic [3:0]                i_op_code,
   input  wire logic [DATA_W-1:0]         i_mem_data,
   input  wire logic [DATA_W-1:0]         i_literal,
   input  wire logic [$clog2(DATA_W)-1:0] i_bit_sel,
   input  wire logic                      i_acc_wr,
   input  wire logic [DATA_W-1:0]         i_acc_wdata,
   output logic      [DATA_W-1:0]         o_acc,
   output logic                           o_mem_wr,
   output logic      [DATA_W-1:0]         o_mem_wdata,
   output logic                           o_done,
   output logic                           o_skip,
   output logic                           o_busy,
   output logic                           o_signed_wrap_flag,
   output logic                           o_nil_result_flag,
   output logic                           o_half_borrow_flag,
   output logic                           o_borrow_out_flag,
   output logic                           o_signed_borrow_flag,
   output logic                           o_chained_nil_flag
);

   // Nibble width, half of the data path
   localparam int HALF = DATA_W / 2;

   // Nibble swap needs an even width of at least 4, two bits per nibble
   if (DATA_W < 4 || (DATA_W % 2) != 0)
   begin
      $error("DATA_W must be even and at least 4");
   end

   // Sequencer group
   seq_state_e          state_reg, state_next;
   logic                done_reg, done_next;
   logic                skip_reg, skip_next;
   logic                busy_reg, busy_next;

   // Accumulator group
   logic [DATA_W-1:0]   acc_reg, acc_next;

   // Memory write-back group
   logic [DATA_W-1:0]   wdata_reg, wdata_next;
   logic                mem_wr_reg, mem_wr_next;

   // Arithmetic flag group
   logic                ov_reg, ov_next;
   logic                z_reg, z_next;
   logic                ac_reg, ac_next;
   logic                c_reg, c_next;
   logic                sc_reg, sc_next;
   logic                cz_reg, cz_next;

   // Decoded request, live only in the execute slot
   logic                take;
   logic                op_sub;
   logic                op_sub_mem;
   logic                op_swap_mem;
   logic                op_swap_acc;
   logic                op_skip_nil;
   logic                op_load_skip;
   logic                op_bit_skip;
   logic                skip_hit;

   // Shared subtractor
   logic [DATA_W-1:0]   sub_b;
   logic [DATA_W:0]     diff;
   logic [HALF:0]       half_diff;
   logic [DATA_W-1:0]   swapped;
   logic                ov_calc;
   logic                z_calc;

   // Decode; a request in the dummy slot is dropped, not queued
   always_comb
   begin
      take         = i_op_valid && (state_reg == ST_EXEC);
      op_sub       = take && (i_op_code == OP_SUB_TO_ACC || i_op_code == OP_SUB_TO_MEM ||
                              i_op_code == OP_SUB_IMM);
      op_sub_mem   = take && (i_op_code == OP_SUB_TO_MEM);
      op_swap_mem  = take && (i_op_code == OP_SWAP_MEM);
      op_swap_acc  = take && (i_op_code == OP_SWAP_ACC);
      op_skip_nil  = take && (i_op_code == OP_SKIP_NIL);
      op_load_skip = take && (i_op_code == OP_LOAD_SKIP);
      op_bit_skip  = take && (i_op_code == OP_BIT_SKIP);
      // Codes 8 to 15 decode to nothing and fall through as no-ops
      // Skip condition per instruction; flags play no part
      skip_hit     = ((op_skip_nil || op_load_skip) && (i_mem_data == '0)) ||
                     (op_bit_skip && !i_mem_data[i_bit_sel]);
   end

   // Subtrahend is the literal only for the immediate form
   always_comb
   begin
      sub_b     = (i_op_code == OP_SUB_IMM) ? i_literal : i_mem_data;
      // Borrow out is the top bit of the widened difference
      diff      = {1'b0, acc_reg} - {1'b0, sub_b};
      half_diff = {1'b0, acc_reg[HALF-1:0]} - {1'b0, sub_b[HALF-1:0]};
      swapped   = {i_mem_data[HALF-1:0], i_mem_data[DATA_W-1:HALF]};
      // Signed overflow only when operand signs differ and the result sign flips
      ov_calc   = (acc_reg[DATA_W-1] != sub_b[DATA_W-1]) && (diff[DATA_W-1] != acc_reg[DATA_W-1]);
      z_calc    = (diff[DATA_W-1:0] == '0);
   end

   // Sequencer; a taken skip costs one extra cycle in which requests are refused
   always_comb
   begin
      state_next = state_reg;
      done_next  = 1'b0;
      skip_next  = 1'b0;
      busy_next  = 1'b0;
      unique case (state_reg)
         ST_EXEC:
         begin
            if (take)
            begin
               // Unknown codes still complete, as a no-op
               done_next = 1'b1;
               // Skip leaves with done so the fetcher can drop the next word
               skip_next = skip_hit;
               if (skip_hit)
               begin
                  state_next = ST_DUMMY;
                  busy_next  = 1'b1;
               end
            end
         end
         ST_DUMMY:
         begin
            // Dummy fetch slot; the skipped instruction is discarded
            state_next = ST_EXEC;
         end
      endcase
   end

   // Sequencer registers; asynchronous reset to constants
   always_ff @(posedge i_ref_clk or negedge i_resetn)
   begin
      if (!i_resetn)
      begin
         state_reg <= ST_EXEC;
         done_reg  <= 1'b0;
         skip_reg  <= 1'b0;
         busy_reg  <= 1'b0;
      end
      else
      begin
         state_reg <= state_next;
         done_reg  <= done_next;
         skip_reg  <= skip_next;
         busy_reg  <= busy_next;
      end
   end

   // Accumulator; an instruction result overrides a same-cycle outside preload
   always_comb
   begin
      acc_next = acc_reg;
      // Preload first so that an instruction below can override it
      if (i_acc_wr)
      begin
         acc_next = i_acc_wdata;
      end
      if (op_sub && !op_sub_mem)
      begin
         acc_next = diff[DATA_W-1:0];
      end
      else if (op_swap_acc)
      begin
         acc_next = swapped;
      end
      else if (op_load_skip)
      begin
         acc_next = i_mem_data;
      end
   end

   // Accumulator register
   always_ff @(posedge i_ref_clk or negedge i_resetn)
   begin
      if (!i_resetn)
      begin
         acc_reg <= DATA_W'(ACC_RESET);
      end
      else
      begin
         acc_reg <= acc_next;
      end
   end

   // Memory write-back; the data register holds the last value written
   always_comb
   begin
      wdata_next  = wdata_reg;
      mem_wr_next = 1'b0;
      if (op_sub_mem)
      begin
         wdata_next  = diff[DATA_W-1:0];
         mem_wr_next = 1'b1;
      end
      else if (op_swap_mem)
      begin
         wdata_next  = swapped;
         mem_wr_next = 1'b1;
      end
      else if (op_skip_nil)
      begin
         // Read-modify-write with the byte unchanged
         wdata_next  = i_mem_data;
         mem_wr_next = 1'b1;
      end
   end

   // Memory write registers
   always_ff @(posedge i_ref_clk or negedge i_resetn)
   begin
      if (!i_resetn)
      begin
         wdata_reg  <= '0;
         mem_wr_reg <= 1'b0;
      end
      else
      begin
         wdata_reg  <= wdata_next;
         mem_wr_reg <= mem_wr_next;
      end
   end

   // Arithmetic flags move only on a subtract; swaps and skips leave them alone
   always_comb
   begin
      ov_next = ov_reg;
      z_next  = z_reg;
      ac_next = ac_reg;
      c_next  = c_reg;
      sc_next = sc_reg;
      cz_next = cz_reg;
      if (op_sub)
      begin
         ov_next = ov_calc;
         z_next  = z_calc;
         ac_next = half_diff[HALF];
         c_next  = diff[DATA_W] ? ~BORROW_NONE : BORROW_NONE;
         sc_next = ov_calc ^ diff[DATA_W-1];
         // None of these forms chain, so chained nil equals nil
         cz_next = z_calc;
      end
   end

   // Flag registers
   always_ff @(posedge i_ref_clk or negedge i_resetn)
   begin
      if (!i_resetn)
      begin
         ov_reg <= FLAG_RESET;
         z_reg  <= FLAG_RESET;
         ac_reg <= FLAG_RESET;
         c_reg  <= FLAG_RESET;
         sc_reg <= FLAG_RESET;
         cz_reg <= FLAG_RESET;
      end
      else
      begin
         ov_reg <= ov_next;
         z_reg  <= z_next;
         ac_reg <= ac_next;
         c_reg  <= c_next;
         sc_reg <= sc_next;
         cz_reg <= cz_next;
      end
   end

   // All outputs straight from flops
   assign o_acc                = acc_reg;
   assign o_mem_wr             = mem_wr_reg;
   assign o_mem_wdata          = wdata_reg;
   assign o_done               = done_reg;
   assign o_skip               = skip_reg;
   assign o_busy               = busy_reg;
   assign o_signed_wrap_flag   = ov_reg;
   assign o_nil_result_flag    = z_reg;
   assign o_half_borrow_flag   = ac_reg;
   assign o_borrow_out_flag    = c_reg;
   assign o_signed_borrow_flag = sc_reg;
   assign o_chained_nil_flag   = cz_reg;

endmodule

// File: design/sub_swap_skip_pkg.sv
// Constants for the subtract, swap and skip execution unit
package sub_swap_skip_pkg;

   // Data path width as documented
   localparam int          DATA_WIDTH     = 8;

   // Operation codes presented on i_op_code
   localparam logic [3:0]  OP_SUB_TO_ACC  = 4'h0;
   localparam logic [3:0]  OP_SUB_TO_MEM  = 4'h1;
   localparam logic [3:0]  OP_SUB_IMM     = 4'h2;
   localparam logic [3:0]  OP_SWAP_MEM    = 4'h3;
   localparam logic [3:0]  OP_SWAP_ACC    = 4'h4;
   localparam logic [3:0]  OP_SKIP_NIL    = 4'h5;
   localparam logic [3:0]  OP_LOAD_SKIP   = 4'h6;
   localparam logic [3:0]  OP_BIT_SKIP    = 4'h7;

   // Reset values
   localparam logic [7:0]  ACC_RESET      = 8'h00;
   localparam logic        FLAG_RESET     = 1'b0;

   // Borrow flag polarity: set means no borrow
   localparam logic        BORROW_NONE    = 1'b1;

   // Sequencer states
   typedef enum logic [0:0] {
      ST_EXEC,
      ST_DUMMY
   } seq_state_e;

endpackage

// File: verification/sub_swap_skip_sva.sv
// Checker for the subtract, swap and skip execution unit
`timescale 1ns/10ps
module sub_swap_skip_sva
   import sub_swap_skip_pkg::*;
#(
   parameter int DATA_W = DATA_WIDTH
)(
   input  wire logic                      i_ref_clk,
   input  wire logic                      i_resetn,
   input  wire logic                      i_op_valid,
   input  wire logic [3:0]                i_op_code,
   input  wire logic [DATA_W-1:0]         i_mem_data,
   input  wire logic [DATA_W-1:0]         i_literal,
   input  wire logic [$clog2(DATA_W)-1:0] i_bit_sel,
   input  wire logic                      i_acc_wr,
   input  wire logic [DATA_W-1:0]         i_acc_wdata,
   input  wire logic [DATA_W-1:0]         o_acc,
   input  wire logic                      o_mem_wr,
   input  wire logic [DATA_W-1:0]         o_mem_wdata,
   input  wire logic                      o_done,
   input  wire logic                      o_skip,
   input  wire logic                      o_busy,
   input  wire logic                      o_signed_wrap_flag,
   input  wire logic                      o_nil_result_flag,
   input  wire logic                      o_half_borrow_flag,
   input  wire logic                      o_borrow_out_flag,
   input  wire logic                      o_signed_borrow_flag,
   input  wire logic                      o_chained_nil_flag
);
   // Combinational terms, looked at one edge later through past values
   wire logic              take = i_op_valid && !o_busy;
   wire logic [DATA_W-1:0] dm   = o_acc - i_mem_data;
   wire logic [DATA_W-1:0] dl   = o_acc - i_literal;
   wire logic [DATA_W-1:0] sw   = {i_mem_data[DATA_W/2-1:0], i_mem_data[DATA_W-1:DATA_W/2]};
   wire logic              nb   = o_acc >= i_mem_data;
   wire logic              bsel = i_mem_data[i_bit_sel];
   wire logic [5:0]        fl   = {o_signed_wrap_flag, o_nil_result_flag, o_half_borrow_flag,
                                   o_borrow_out_flag, o_signed_borrow_flag, o_chained_nil_flag};
   default clocking @(posedge i_ref_clk); endclocking
   default disable iff (!i_resetn);

   answer_next_a: assert property (take |=> o_done) else $error("done missing after request");
   busy_refuse_a: assert property (o_busy |=> !o_done) else $error("request taken in dummy cycle");
   dummy_cycle_a: assert property (o_skip |-> o_busy ##1 !o_busy) else $error("dummy cycle wrong");
   // Preload excluded: it would legally move the accumulator
   sub_mem_a: assert property (take && !i_acc_wr && i_op_code == OP_SUB_TO_MEM |=>
      o_mem_wr && o_mem_wdata == $past(dm) && $stable(o_acc) && o_borrow_out_flag == $past(nb))
      else $error("subtract into memory wrong");
   sub_acc_a: assert property (take && i_op_code == OP_SUB_TO_ACC |=>
      o_acc == $past(dm) && !o_mem_wr && o_borrow_out_flag == $past(nb) && o_chained_nil_flag == o_nil_result_flag)
      else $error("subtract into accumulator wrong");
   sub_imm_a: assert property (take && i_op_code == OP_SUB_IMM |=>
      o_acc == $past(dl) && o_nil_result_flag == (o_acc == 0)) else $error("subtract immediate wrong");
   swap_mem_a: assert property (take && i_op_code == OP_SWAP_MEM |=>
      o_mem_wr && o_mem_wdata == $past(sw)) else $error("swap in place wrong");
   swap_acc_a: assert property (take && i_op_code == OP_SWAP_ACC |=>
      o_acc == $past(sw) && !o_mem_wr) else $error("swap into accumulator wrong");
   skip_nil_a: assert property (take && i_op_code == OP_SKIP_NIL |=>
      o_mem_wr && o_mem_wdata == $past(i_mem_data) && o_skip == (o_mem_wdata == 0)) else $error("skip if nil wrong");
   load_skip_a: assert property (take && i_op_code == OP_LOAD_SKIP |=>
      o_acc == $past(i_mem_data) && o_skip == (o_acc == 0)) else $error("load and skip wrong");
   bit_skip_a: assert property (take && i_op_code == OP_BIT_SKIP |=>
      o_skip == !$past(bsel) && !o_mem_wr) else $error("bit test skip wrong");
   flags_kept_a: assert property (take && i_op_code >= OP_SWAP_MEM |=> $stable(fl))
      else $error("flags moved on non-subtract");

   cover property (o_skip);
   cover property (take && i_op_code == OP_SUB_TO_MEM);
   cover property (o_busy && i_op_valid);
endmodule

bind subtract_swap_skip_instr_exec sub_swap_skip_sva #(.DATA_W(DATA_W)) i_chk (
   .i_ref_clk            (i_ref_clk),
   .i_resetn             (i_resetn),
   .i_op_valid           (i_op_valid),
   .i_op_code            (i_op_code),
   .i_mem_data           (i_mem_data),
   .i_literal            (i_literal),
   .i_bit_sel            (i_bit_sel),
   .i_acc_wr             (i_acc_wr),
   .i_acc_wdata          (i_acc_wdata),
   .o_acc                (o_acc),
   .o_mem_wr             (o_mem_wr),
   .o_mem_wdata          (o_mem_wdata),
   .o_done               (o_done),
   .o_skip               (o_skip),
   .o_busy               (o_busy),
   .o_signed_wrap_flag   (o_signed_wrap_flag),
   .o_nil_result_flag    (o_nil_result_flag),
   .o_half_borrow_flag   (o_half_borrow_flag),
   .o_borrow_out_flag    (o_borrow_out_flag),
   .o_signed_borrow_flag (o_signed_borrow_flag),
   .o_chained_nil_flag   (o_chained_nil_flag)
);

// File: verification/testbench.sv
// Self-checking bench for the subtract, swap and skip execution unit
`timescale 1ns/10ps
module testbench;
   import sub_swap_skip_pkg::*;
   logic        i_ref_clk = 0, i_resetn = 0, i_op_valid = 0, i_acc_wr = 0;
   logic [3:0]  i_op_code = 0;
   logic [7:0]  i_mem_data = 0, i_literal = 0, i_acc_wdata = 0, o_acc, o_mem_wdata, acc_m = 0, wd_m = 0;
   logic [2:0]  i_bit_sel = 0;
   logic        o_mem_wr, o_done, o_skip, o_busy;
   wire  [5:0]  fl;
   logic [5:0]  fl_m = 0;
   logic [24:0] exp_q[$];
   logic [31:0] seed = 32'h2e95a5c3, r;
   int          mismatches = 0, num_checks = 0, cyc = 0;

   subtract_swap_skip_instr_exec i_dut (.i_ref_clk(i_ref_clk), .i_resetn(i_resetn), .i_op_valid(i_op_valid),
      .i_op_code(i_op_code), .i_mem_data(i_mem_data), .i_literal(i_literal), .i_bit_sel(i_bit_sel),
      .i_acc_wr(i_acc_wr), .i_acc_wdata(i_acc_wdata), .o_acc(o_acc), .o_mem_wr(o_mem_wr),
      .o_mem_wdata(o_mem_wdata), .o_done(o_done), .o_skip(o_skip), .o_busy(o_busy),
      .o_signed_wrap_flag(fl[5]), .o_nil_result_flag(fl[4]), .o_half_borrow_flag(fl[3]),
      .o_borrow_out_flag(fl[2]), .o_signed_borrow_flag(fl[1]), .o_chained_nil_flag(fl[0]));

   initial forever #50 i_ref_clk = ~i_ref_clk;

   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction

   task automatic check(string name, logic [24:0] seen, logic [24:0] exp);
      num_checks++;
      if (seen !== exp)
      begin
         mismatches++;
         $display("MISMATCH %s expected %h seen %h", name, exp, seen);
      end
   endtask

   task automatic complete_run();
      $display("checks %0d mismatches %0d", num_checks, mismatches);
      if (mismatches == 0 && num_checks > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask

   // Drives one instruction, notes the expected outcome; valid stays up so ops run back to back
   task automatic issue(logic [3:0] c, logic [7:0] m, logic [7:0] l, logic [2:0] b, logic pw, logic [7:0] pd);
      logic [7:0] x, d;
      logic       sk, w, mw;
      i_op_valid = 1;
      {i_op_code, i_mem_data, i_literal, i_bit_sel, i_acc_wr, i_acc_wdata} = {c, m, l, b, pw, pd};
      x = (c == OP_SUB_IMM) ? l : m;
      d = acc_m - x;
      w = (acc_m[7] ^ x[7]) & (d[7] ^ acc_m[7]);
      mw = c inside {OP_SUB_TO_MEM, OP_SWAP_MEM, OP_SKIP_NIL};
      sk = (c inside {OP_SKIP_NIL, OP_LOAD_SKIP} && m == 0) || (c == OP_BIT_SKIP && !m[b]);
      if (c <= OP_SUB_IMM)
         fl_m = {w, d == 0, acc_m[3:0] < x[3:0], acc_m >= x, w ^ d[7], d == 0};
      if (c == OP_SUB_TO_MEM) wd_m = d;
      if (c == OP_SWAP_MEM) wd_m = {m[3:0], m[7:4]};
      if (c == OP_SKIP_NIL) wd_m = m;
      // Instruction result beats a same-cycle preload
      if (c == OP_SUB_TO_ACC || c == OP_SUB_IMM) acc_m = d;
      else if (c == OP_SWAP_ACC) acc_m = {m[3:0], m[7:4]};
      else if (c == OP_LOAD_SKIP) acc_m = m;
      else if (pw) acc_m = pd;
      exp_q.push_back({acc_m, mw, wd_m, sk, sk, fl_m});
      @(negedge i_ref_clk);
      if (sk)
      begin
         r = rnd();
         i_op_code = r[3:0]; // Must be ignored in the dummy cycle
         i_acc_wr = 0;
         @(negedge i_ref_clk);
      end
   endtask

   // Result watcher: oldest note against each done pulse
   always @(negedge i_ref_clk)
      if (o_done === 1'b1)
      begin
         if (exp_q.size() == 0) check("spurious_done", 25'h1, 25'h0);
         else check("result", {o_acc, o_mem_wr, o_mem_wdata, o_skip, o_busy, fl}, exp_q.pop_front());
      end

   // Hang guard, far above the roughly 530 to 1050 cycles the run needs
   always @(posedge i_ref_clk)
   begin
      cyc++;
      if (cyc == 3000)
      begin
         mismatches++;
         complete_run();
      end
   end

   initial
   begin
      repeat (10) @(negedge i_ref_clk);
      i_resetn = 1;
      check("reset", {o_acc, fl, o_done, o_busy}, 25'h0);
      issue(4'h8, 8'h00, 8'h00, 3'h0, 1'b1, 8'h05);
      issue(OP_SUB_TO_MEM, 8'h07, 8'h00, 3'h0, 1'b0, 8'h00);
      for (int c = 0; c < 16; c++)
         issue(c[3:0], 8'h00, 8'h80, c[2:0], 1'b0, 8'h00);
      repeat (500)
      begin
         r = rnd();
         issue(r[3:0], (r[7:4] == 0) ? 8'h00 : r[15:8], r[23:16], r[26:24], r[31:29] == 0, r[11:4]);
      end
      i_op_valid = 0;
      repeat (3) @(negedge i_ref_clk);
      if (exp_q.size() != 0) check("pending", 25'h1, 25'h0);
      complete_run();
   end
endmodule
